/* File: logic/tsv_pkg.sv */
package tsv_pkg;

    // -------------------------------------------------------------
    // Register map (word addresses on the plain register port)
    // -------------------------------------------------------------
    localparam int          ADDR_W       = 3;
    localparam int          DATA_W       = 16;
    localparam logic [2:0]  ADDR_CTRL    = 3'h0;
    localparam logic [2:0]  ADDR_DBAND   = 3'h1;
    localparam logic [2:0]  ADDR_OPEN_T  = 3'h2;
    localparam logic [2:0]  ADDR_CLOSE_T = 3'h3;
    localparam logic [2:0]  ADDR_MIN_T   = 3'h4;
    localparam logic [2:0]  ADDR_STATUS  = 3'h5;
    localparam logic [2:0]  ADDR_LAST    = 3'h6;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_FB_BIT    = 1;
    localparam int CTRL_FAIL_LSB  = 2;
    localparam int STAT_OPEN_BIT  = 0;
    localparam int STAT_CLOSE_BIT = 1;
    localparam int STAT_HOME_BIT  = 2;
    localparam int STAT_LO_BIT    = 3;
    localparam int STAT_HI_BIT    = 4;
    localparam int STAT_FBERR_BIT = 5;
    localparam int STAT_REFUS_BIT = 6;
    localparam int STAT_STATE_LSB = 8;

    localparam logic [1:0] FAIL_HOLD  = 2'h0;
    localparam logic [1:0] FAIL_OPEN  = 2'h1;
    localparam logic [1:0] FAIL_CLOSE = 2'h2;

    // -------------------------------------------------------------
    // Reset values (times in 100 ms ticks)
    // -------------------------------------------------------------
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] DBAND_RST   = 16'h0010;
    localparam logic [15:0] OPEN_T_RST  = 16'h0258;
    localparam logic [15:0] CLOSE_T_RST = 16'h0258;
    localparam logic [15:0] MIN_T_RST   = 16'h0005;

    // -------------------------------------------------------------
    // Control signal scale: 16'h4000 stands for 100 %
    // -------------------------------------------------------------
    localparam logic [15:0] SIG_FULL  = 16'h4000;
    localparam int          SIG_SHIFT = 14;
    localparam logic [15:0] POS_HYST  = 16'h0040;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_HZ       = 25_000_000;
    localparam int TICK_TIME_MS = 100;
    localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;

    typedef enum logic [5:0] {
        ST_IDLE      = 6'b00_0001,
        ST_OPEN      = 6'b00_0010,
        ST_CLOSE     = 6'b00_0100,
        ST_HOME      = 6'b00_1000,
        ST_END_OPEN  = 6'b01_0000,
        ST_END_CLOSE = 6'b10_0000
    } tsv_state_t;

endpackage : tsv_pkg

/* File: logic/tsv_relay_drv.sv */
`timescale 1ns/100ps
module tsv_relay_drv (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic open_req,
    input  wire logic close_req,
    output logic      open_relay,
    output logic      close_relay
);
    // -------------------------------------------------------------
    // Interlock
    // -------------------------------------------------------------
    // A reversal passes through one cycle with both relays off
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            open_relay  <= 1'b0;
            close_relay <= 1'b0;
        end else begin
            open_relay  <= open_req && !close_req && !close_relay;
            close_relay <= close_req && !open_req && !open_relay;
        end
    end
endmodule : tsv_relay_drv

/* File: logic/tsv_tick_div.sv */
`timescale 1ns/100ps
module tsv_tick_div #(
    parameter int DIV = 2_500_000
) (
    input  wire logic ref_clk,
    input  wire logic nrst,
    output logic      tick
);
    logic [31:0] cnt_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt_reg <= 32'h0000_0000;
            tick    <= 1'b0;
        end else if (cnt_reg >= 32'(DIV - 1)) begin
            cnt_reg <= 32'h0000_0000;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            tick    <= 1'b0;
        end
    end
endmodule : tsv_tick_div

/* File: logic/tsv_valve_ctrl.sv */
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// - Two valve algorithms exist, open-loop from the control signal or closed-loop on the position input.
// - Valve control runs when enabled, and the feedback select bit picks the closed-loop algorithm.
// - While the deviation is inside the position deadband only end-of-travel, homing and fail-state drives run.
// - An auto-tuning request is refused while valve control is selected.
// - In feedback mode a failed position signal puts the valve in the configured fail state.
// - Open-loop mode uses full open time, full close time and minimum work time.
// - Each control signal change outside the position deadband becomes relay on-time scaled by the full open or close time.
// - Reaching 0 % or 100 % lengthens the drive automatically to remove position drift.
// - At 100 % the open relay runs one full open time, at 0 % the close relay one full close time.
// - End-of-travel drive stops as soon as the control signal leaves its extreme.
// - After reset and after any write of the open or close time the valve is driven fully closed.
// - Full open time and full close time are independent settings.
module tsv_valve_ctrl
    import tsv_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic [ADDR_W-1:0]  bus_addr,
    input  wire logic [DATA_W-1:0]  bus_wdata,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    output logic      [DATA_W-1:0]  bus_rdata,
    input  wire logic [15:0]        ctrl_sig,
    input  wire logic signed [15:0] deviation,
    input  wire logic [15:0]        valve_pos,
    input  wire logic               fb_error,
    input  wire logic               tune_req,
    output logic                    tune_start,
    output logic                    tune_refused,
    output logic                    open_relay,
    output logic                    close_relay
);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    logic [15:0]        ctrl_reg;
    logic [15:0]        dband_reg;
    logic [15:0]        open_t_reg;
    logic [15:0]        close_t_reg;
    logic [15:0]        min_t_reg;
    logic [15:0]        last_sig_reg;
    logic signed [39:0] acc_reg;
    logic signed [39:0] acc_next;
    logic [15:0]        timer_reg;
    logic               home_req_reg;
    logic               hi_done_reg;
    logic               lo_done_reg;
    logic               refused_reg;
    tsv_state_t         state_reg;
    logic               tick;
    logic               enable;
    logic               fb_mode;
    logic [1:0]         fail_sel;
    logic               in_band;
    logic               sig_max;
    logic               sig_min;
    logic               eval;
    logic               end_go_hi;
    logic               end_go_lo;
    logic               step_eval;
    logic               fb_open;
    logic               fb_close;
    logic signed [16:0] delta;
    logic signed [39:0] scaled;
    logic signed [39:0] acc_sum;
    logic [39:0]        acc_mag;
    logic [23:0]        pulse_ticks;
    logic [15:0]        pulse_len;
    logic               pulse_ok;
    logic               time_wr;
    logic               open_req;
    logic               close_req;

    // Absolute value of a signed 16-bit quantity
    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        logic signed [16:0] w;
        w = 17'(v);
        if (w < 0) begin
            w = -w;
        end
        return (w > 17'sh0_FFFF) ? 16'hFFFF : w[15:0];
    endfunction : abs16

    // -------------------------------------------------------------
    // Time base
    // -------------------------------------------------------------
    tsv_tick_div #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (tick)
    );

    // -------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------
    assign enable   = ctrl_reg[CTRL_EN_BIT];
    assign fb_mode  = ctrl_reg[CTRL_FB_BIT];
    assign fail_sel = ctrl_reg[CTRL_FAIL_LSB +: 2];
    assign time_wr  = bus_wr && (bus_addr == ADDR_OPEN_T ||
                                 bus_addr == ADDR_CLOSE_T);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_reg    <= CTRL_RST;
            dband_reg   <= DBAND_RST;
            open_t_reg  <= OPEN_T_RST;
            close_t_reg <= CLOSE_T_RST;
            min_t_reg   <= MIN_T_RST;
        end else if (bus_wr) begin
            unique case (bus_addr)
                ADDR_CTRL:    ctrl_reg    <= bus_wdata;
                ADDR_DBAND:   dband_reg   <= bus_wdata;
                ADDR_OPEN_T:  open_t_reg  <= bus_wdata;
                ADDR_CLOSE_T: close_t_reg <= bus_wdata;
                ADDR_MIN_T:   min_t_reg   <= bus_wdata;
                default: begin
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bus_rdata <= 16'h0000;
        end else if (bus_rd) begin
            unique case (bus_addr)
                ADDR_CTRL:    bus_rdata <= ctrl_reg;
                ADDR_DBAND:   bus_rdata <= dband_reg;
                ADDR_OPEN_T:  bus_rdata <= open_t_reg;
                ADDR_CLOSE_T: bus_rdata <= close_t_reg;
                ADDR_MIN_T:   bus_rdata <= min_t_reg;
                ADDR_STATUS: begin
                    bus_rdata                 <= 16'h0000;
                    bus_rdata[STAT_OPEN_BIT]  <= open_relay;
                    bus_rdata[STAT_CLOSE_BIT] <= close_relay;
                    bus_rdata[STAT_HOME_BIT]  <= home_req_reg;
                    bus_rdata[STAT_LO_BIT]    <= lo_done_reg;
                    bus_rdata[STAT_HI_BIT]    <= hi_done_reg;
                    bus_rdata[STAT_FBERR_BIT] <= fb_error;
                    bus_rdata[STAT_REFUS_BIT] <= refused_reg;
                    bus_rdata[STAT_STATE_LSB +: 6] <= state_reg;
                end
                ADDR_LAST:    bus_rdata <= last_sig_reg;
                default:      bus_rdata <= 16'h0000;
            endcase
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    // -------------------------------------------------------------
    // Auto-tuning gate
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tune_start   <= 1'b0;
            tune_refused <= 1'b0;
        end else begin
            tune_start   <= tune_req && !enable;
            tune_refused <= tune_req && enable;
        end
    end

    // Sticky refusal flag; a new refusal beats a clearing write
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            refused_reg <= 1'b0;
        end else if (tune_req && enable) begin
            refused_reg <= 1'b1;
        end else if (bus_wr && bus_addr == ADDR_STATUS &&
                     bus_wdata[STAT_REFUS_BIT]) begin
            refused_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // Decisions
    // -------------------------------------------------------------
    assign in_band   = abs16(deviation) <= dband_reg;
    assign sig_max   = ctrl_sig >= SIG_FULL;
    assign sig_min   = ctrl_sig == 16'h0000;
    assign eval      = tick && enable && state_reg == ST_IDLE &&
                       !home_req_reg;
    assign end_go_hi = !fb_mode && sig_max && !hi_done_reg;
    assign end_go_lo = !fb_mode && sig_min && !lo_done_reg;
    assign step_eval = eval && !fb_mode && !end_go_hi && !end_go_lo;

    // Closed-loop direction, hysteresis keeps the relays from chatter
    always_comb begin
        fb_open  = 1'b0;
        fb_close = 1'b0;
        if (fb_error) begin
            fb_open  = fail_sel == FAIL_OPEN;
            fb_close = fail_sel == FAIL_CLOSE;
        end else if (!in_band) begin
            fb_open  = {1'b0, ctrl_sig} >
                       {1'b0, valve_pos} + {1'b0, POS_HYST};
            fb_close = {1'b0, valve_pos} >
                       {1'b0, ctrl_sig} + {1'b0, POS_HYST};
        end
    end

    // -------------------------------------------------------------
    // Open-loop demand accumulator
    // -------------------------------------------------------------
    // Demand is kept in signal*tick units so no fraction is lost
    always_comb begin
        delta   = 17'(signed'({1'b0, ctrl_sig})) -
                  17'(signed'({1'b0, last_sig_reg}));
        scaled  = 40'sh00_0000_0000;
        if (!in_band) begin
            if (delta > 0) begin
                scaled = 40'(delta) *
                         40'(signed'({1'b0, open_t_reg}));
            end else begin
                scaled = 40'(delta) *
                         40'(signed'({1'b0, close_t_reg}));
            end
        end
        acc_sum     = acc_reg + scaled;
        acc_mag     = (acc_sum < 0) ? 40'(-acc_sum) : 40'(acc_sum);
        pulse_ticks = acc_mag[SIG_SHIFT +: 24];
        pulse_len   = (pulse_ticks > 24'h00_FFFF) ? 16'hFFFF
                                                  : pulse_ticks[15:0];
        pulse_ok    = pulse_len != 16'h0000 &&
                      pulse_len >= min_t_reg;
        acc_next    = acc_sum;
        if (pulse_ok) begin
            if (acc_sum < 0) begin
                acc_next = acc_sum +
                    (40'(signed'({1'b0, pulse_len})) <<< SIG_SHIFT);
            end else begin
                acc_next = acc_sum -
                    (40'(signed'({1'b0, pulse_len})) <<< SIG_SHIFT);
            end
        end
    end

    // Short demand stays in the accumulator for a later pulse
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            acc_reg      <= 40'sh00_0000_0000;
            last_sig_reg <= 16'h0000;
        end else if (!enable || (eval && (fb_mode || end_go_hi ||
                                          end_go_lo))) begin
            acc_reg      <= 40'sh00_0000_0000;
            last_sig_reg <= ctrl_sig;
        end else if (state_reg == ST_HOME && tick &&
                     timer_reg <= 16'h0001) begin
            acc_reg      <= 40'sh00_0000_0000;
            last_sig_reg <= 16'h0000;
        end else if (step_eval) begin
            acc_reg      <= acc_next;
            last_sig_reg <= ctrl_sig;
        end
    end

    // -------------------------------------------------------------
    // Homing and end-of-travel bookkeeping
    // -------------------------------------------------------------
    // A time write during homing re-arms it; the request wins
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            home_req_reg <= 1'b1;
        end else if (time_wr) begin
            home_req_reg <= 1'b1;
        end else if (tick && enable && state_reg == ST_IDLE) begin
            home_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hi_done_reg <= 1'b0;
        end else if (!sig_max) begin
            hi_done_reg <= 1'b0;
        end else if (state_reg == ST_END_OPEN && tick &&
                     timer_reg <= 16'h0001) begin
            hi_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lo_done_reg <= 1'b0;
        end else if (!sig_min) begin
            lo_done_reg <= 1'b0;
        end else if (state_reg == ST_END_CLOSE && tick &&
                     timer_reg <= 16'h0001) begin
            lo_done_reg <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Drive sequencer
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst || !enable) begin
            state_reg <= ST_IDLE;
            timer_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (tick && home_req_reg && !time_wr) begin
                        state_reg <= ST_HOME;
                        timer_reg <= close_t_reg;
                    end else if (eval && fb_mode) begin
                        if (fb_open) begin
                            state_reg <= ST_OPEN;
                            timer_reg <= 16'h0001;
                        end else if (fb_close) begin
                            state_reg <= ST_CLOSE;
                            timer_reg <= 16'h0001;
                        end
                    end else if (eval && end_go_hi) begin
                        state_reg <= ST_END_OPEN;
                        timer_reg <= open_t_reg;
                    end else if (eval && end_go_lo) begin
                        state_reg <= ST_END_CLOSE;
                        timer_reg <= close_t_reg;
                    end else if (step_eval && pulse_ok) begin
                        state_reg <= (acc_sum < 0) ? ST_CLOSE
                                                   : ST_OPEN;
                        timer_reg <= pulse_len;
                    end
                end
                ST_OPEN, ST_CLOSE, ST_HOME: begin
                    if (tick) begin
                        if (timer_reg <= 16'h0001) begin
                            state_reg <= ST_IDLE;
                            timer_reg <= 16'h0000;
                        end else begin
                            timer_reg <= timer_reg - 16'h0001;
                        end
                    end
                end
                ST_END_OPEN: begin
                    if (!sig_max) begin
                        state_reg <= ST_IDLE;
                        timer_reg <= 16'h0000;
                    end else if (tick) begin
                        if (timer_reg <= 16'h0001) begin
                            state_reg <= ST_IDLE;
                            timer_reg <= 16'h0000;
                        end else begin
                            timer_reg <= timer_reg - 16'h0001;
                        end
                    end
                end
                ST_END_CLOSE: begin
                    if (!sig_min) begin
                        state_reg <= ST_IDLE;
                        timer_reg <= 16'h0000;
                    end else if (tick) begin
                        if (timer_reg <= 16'h0001) begin
                            state_reg <= ST_IDLE;
                            timer_reg <= 16'h0000;
                        end else begin
                            timer_reg <= timer_reg - 16'h0001;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    timer_reg <= 16'h0000;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // Relay outputs
    // -------------------------------------------------------------
    assign open_req  = state_reg == ST_OPEN || state_reg == ST_END_OPEN;
    assign close_req = state_reg == ST_CLOSE || state_reg == ST_HOME ||
                       state_reg == ST_END_CLOSE;

    tsv_relay_drv u_relay (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .open_req    (open_req),
        .close_req   (close_req),
        .open_relay  (open_relay),
        .close_relay (close_relay)
    );

endmodule : tsv_valve_ctrl

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import tsv_pkg::*;
    logic               ref_clk = 1'b0, nrst = 1'b0, fb_error = 1'b0;
    logic               bus_wr = 1'b0, bus_rd = 1'b0, tune_req = 1'b0;
    logic               tune_start, tune_refused, open_relay, close_relay;
    logic [ADDR_W-1:0]  bus_addr = '0;
    logic [DATA_W-1:0]  bus_wdata = '0, bus_rdata;
    logic [15:0]        ctrl_sig = '0, valve_pos;
    logic signed [15:0] deviation = 16'sh0100;
    int                 err_count = 0, compares = 0, no, nc;

    always #20 ref_clk = ~ref_clk;
    // Short tick so full travel times stay a few dozen cycles
    tsv_valve_ctrl #(.TICK_DIV(4)) dut_u (.ref_clk, .nrst, .bus_addr,
        .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .ctrl_sig, .deviation,
        .valve_pos, .fb_error, .tune_req, .tune_start, .tune_refused,
        .open_relay, .close_relay);
    tsv_valve_mdl mdl_u (.ref_clk, .open_relay, .close_relay, .valve_pos);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        // Gap edge: a next write never drops and raises bus_wr at once
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, e);
        @(posedge ref_clk);
    endtask : rd
    // Relay on-cycles over 30 ticks, enough for any single drive
    task automatic cnt(input logic [15:0] sig);
        ctrl_sig <= sig;
        no = 0;
        nc = 0;
        // Sampled mid-cycle, away from the edge that moves the relays
        repeat (120) begin
            @(negedge ref_clk);
            no += open_relay;
            nc += close_relay;
        end
        @(posedge ref_clk);
    endtask : cnt
    task automatic t_tune(input logic en);
        tune_req <= 1'b1;
        @(posedge ref_clk);
        tune_req <= 1'b0;
        #1 chk({14'h0, tune_start, tune_refused}, {14'h0, !en, en});
        @(posedge ref_clk);
        $display("tune test done");
    endtask : t_tune
    task automatic t_open;
        rd(ADDR_DBAND, DBAND_RST);
        rd(ADDR_OPEN_T, OPEN_T_RST);
        rd(3'h7, 16'h0000);
        wr(ADDR_OPEN_T, 16'h0008);
        wr(ADDR_CLOSE_T, 16'h0006);
        wr(ADDR_MIN_T, 16'h0003);
        rd(ADDR_CLOSE_T, 16'h0006);
        wr(ADDR_CTRL, 16'h0001);
        cnt(16'h2000);
        chk(16'(nc), 16'h0018);
        chk(16'(no), 16'h0010);
        cnt(16'h2800);
        chk(16'(no + nc), 16'h0000);
        cnt(16'h3800);
        chk(16'(no), 16'h000c);
        deviation <= 16'sh0000;
        cnt(16'h2000);
        chk(16'(no + nc), 16'h0000);
        cnt(16'h3800);
        rd(ADDR_LAST, 16'h3800);
        deviation <= 16'sh0100;
        cnt(SIG_FULL);
        chk(16'(no), 16'h0020);
        $display("open loop test done");
    endtask : t_open
    task automatic t_end;
        cnt(16'h0000);
        chk(16'(nc), 16'h0018);
        // Leave the top mid-drive: the relay falls two edges later
        ctrl_sig <= SIG_FULL;
        repeat (20) @(posedge ref_clk);
        cnt(16'h3000);
        chk(16'(no), 16'h0002);
        chk(16'(nc), 16'h0000);
        wr(ADDR_OPEN_T, 16'h0008);
        cnt(16'h3000);
        chk(16'(nc), 16'h0018);
        chk(16'(no), 16'h0018);
        $display("end of travel test done");
    endtask : t_end
    task automatic t_fb;
        fb_error <= 1'b1;
        wr(ADDR_CTRL, 16'h0003);
        cnt(16'h3000);
        chk(16'(no + nc), 16'h0000);
        wr(ADDR_CTRL, 16'h000b);
        cnt(16'h3000);
        chk({15'h0, nc > 0}, 16'h0001);
        chk(16'(no), 16'h0000);
        wr(ADDR_CTRL, 16'h0007);
        // A close pulse may still be in flight
        repeat (8) @(posedge ref_clk);
        cnt(16'h3000);
        chk({15'h0, no > 0}, 16'h0001);
        chk(16'(nc), 16'h0000);
        fb_error <= 1'b0;
        cnt(16'h3000);
        chk({15'h0, no > 0}, 16'h0001);
        chk(16'(nc), 16'h0000);
        t_tune(1'b1);
        wr(ADDR_CTRL, 16'h0000);
        repeat (8) @(posedge ref_clk);
        cnt(16'h0000);
        chk(16'(no + nc), 16'h0000);
        rd(ADDR_STATUS, 16'h0140);
        wr(ADDR_STATUS, 16'h0040);
        rd(ADDR_STATUS, 16'h0100);
        $display("feedback test done");
    endtask : t_fb
    task automatic end_sim;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        #150_000;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_tune(1'b0);
        t_open();
        t_end();
        t_fb();
        end_sim();
    end
endmodule : tb_top

/* File: verification/tsv_valve_ctrl_chk.sv */
`timescale 1ns/100ps
module tsv_valve_chk
    import tsv_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic              ref_clk,
    input wire logic              nrst,
    input wire logic              bus_rd,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic              tune_req,
    input wire logic              tune_start,
    input wire logic              tune_refused,
    input wire logic              open_relay,
    input wire logic              close_relay
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_relay_excl: assert property (!(open_relay && close_relay))
        else $error("both relays on");
    a_open_rev: assert property ($rose(open_relay) |-> !$past(close_relay))
        else $error("open without gap");
    a_close_rev: assert property ($rose(close_relay) |-> !$past(open_relay))
        else $error("close without gap");
    a_tune_resp: assert property (tune_req |=> tune_start ^ tune_refused)
        else $error("tune request unanswered");
    a_tune_cause: assert property ((tune_start || tune_refused) |-> $past(tune_req))
        else $error("tune answer without request");
    a_tune_excl: assert property (!(tune_start && tune_refused))
        else $error("tune started and refused");
    a_rd_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !open_relay && !close_relay && !tune_start)
        else $error("output active after reset");
endmodule : tsv_valve_chk

bind tsv_valve_ctrl tsv_valve_chk #(.TICK_DIV(TICK_DIV)) chk_u (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .bus_rd       (bus_rd),
    .bus_rdata    (bus_rdata),
    .tune_req     (tune_req),
    .tune_start   (tune_start),
    .tune_refused (tune_refused),
    .open_relay   (open_relay),
    .close_relay  (close_relay)
);

/* File: verification/tsv_valve_mdl.sv */
`timescale 1ns/100ps
module tsv_valve_mdl (
    input  wire logic        ref_clk,
    input  wire logic        open_relay,
    input  wire logic        close_relay,
    output logic      [15:0] valve_pos
);
    // Travel 16'h0020 a cycle, clamped so the position never wraps
    initial valve_pos = 16'h2000;
    always @(posedge ref_clk) begin
        if (open_relay && valve_pos < 16'h3fe0)
            valve_pos <= valve_pos + 16'h0020;
        else if (close_relay && valve_pos > 16'h001f)
            valve_pos <= valve_pos - 16'h0020;
    end
endmodule : tsv_valve_mdl
